// ### pec_pkg.sv
// Purpose : shared constants for proximity and ambient calibration
// Assumes : 16-bit converter samples, word-wide register port
// Notes   : offsets are word indices on the register port
package pec_pkg;

   localparam int unsigned PEC_NUM_STAGES = 12;
   localparam int unsigned PEC_DATA_W     = 16;
   localparam int unsigned PEC_FF_DEPTH   = 4;

   // register offsets
   localparam logic [7:0] PEC_OFS_HOLD_SKIP = 8'h02;
   localparam logic [7:0] PEC_OFS_CTRL1     = 8'h03;
   localparam logic [7:0] PEC_OFS_RECAL     = 8'h04;
   localparam logic [7:0] PEC_OFS_SLOW_LVL  = 8'h05;
   localparam logic [7:0] PEC_OFS_PROX_STAT = 8'h06;
   localparam logic [7:0] PEC_OFS_CAL_STAT  = 8'h07;
   localparam logic [7:0] PEC_OFS_THR_STAT  = 8'h08;

   // per-stage banks: upper nibble bank, lower nibble stage
   localparam logic [3:0] PEC_BANK_UP_OFS  = 4'h1;
   localparam logic [3:0] PEC_BANK_LO_OFS  = 4'h2;
   localparam logic [3:0] PEC_BANK_AMBIENT = 4'h3;
   localparam logic [3:0] PEC_BANK_UP_THR  = 4'h4;
   localparam logic [3:0] PEC_BANK_LO_THR  = 4'h5;

   // field positions
   localparam int unsigned PEC_SKIP_LSB     = 0;
   localparam int unsigned PEC_FP_HOLD_LSB  = 4;
   localparam int unsigned PEC_LP_HOLD_LSB  = 8;
   localparam int unsigned PEC_RLVL_LSB     = 0;
   localparam int unsigned PEC_DRATE_LSB    = 8;
   localparam int unsigned PEC_FP_RECAL_LSB = 0;
   localparam int unsigned PEC_LP_RECAL_LSB = 10;

   // reset values
   localparam logic [15:0] PEC_RST_HOLD_SKIP = 16'h0000;
   localparam logic [15:0] PEC_RST_CTRL1     = 16'h0000;
   localparam logic [15:0] PEC_RST_RECAL     = 16'h0000;
   localparam logic [15:0] PEC_RST_SLOW_LVL  = 16'h0000;
   localparam logic [15:0] PEC_RST_STAGE_OFS = 16'h0000;

   // scaling
   localparam int unsigned PEC_LSB_SCALE     = 4;
   localparam int unsigned PEC_FP_HOLD_SHIFT = 4;
   localparam int unsigned PEC_LP_HOLD_SHIFT = 2;
   localparam int unsigned PEC_AMB_SHIFT     = 4;
   localparam int unsigned PEC_PCT_SHIFT     = 2;

endpackage

// ### pec_stage_if.sv
// Purpose : carrier between the top and one stage engine
// Assumes : one instance per conversion stage
// Notes   : configuration fields are copies of the shared registers, except up_ofs and lo_ofs which come from the stage's own registers
`timescale 1ns/1ns
interface pec_stage_if;
   logic        smp_vld;
   logic [15:0] smp;
   logic        seq_tick;
   logic        lowp;
   logic [3:0]  skip;
   logic [3:0]  fp_hold;
   logic [3:0]  lp_hold;
   logic [9:0]  fp_recal;
   logic [5:0]  lp_recal;
   logic [7:0]  recal_lvl;
   logic [5:0]  det_rate;
   logic [15:0] slow_lvl;
   logic [15:0] up_ofs;
   logic [15:0] lo_ofs;
   logic        prox;
   logic        cal_en;
   logic [15:0] ambient;
   logic [16:0] up_thr;
   logic [15:0] lo_thr;

   modport top   (output smp_vld, smp, seq_tick, lowp, skip, fp_hold, lp_hold, fp_recal,
                  lp_recal, recal_lvl, det_rate, slow_lvl, up_ofs, lo_ofs,
                  input prox, cal_en, ambient, up_thr, lo_thr);
   modport stage (input smp_vld, smp, seq_tick, lowp, skip, fp_hold, lp_hold, fp_recal,
                  lp_recal, recal_lvl, det_rate, slow_lvl, up_ofs, lo_ofs,
                  output prox, cal_en, ambient, up_thr, lo_thr);
endinterface

// ### pec_stage.sv
// Purpose : proximity, calibration hold and recalibration for one stage
// Assumes : seq_tick pulses once per conversion sequence
// Notes   : first sample after reset seeds fifo and ambient
`timescale 1ns/1ns
module pec_stage
   import pec_pkg::*;
(
   input  wire logic  ref_clk_in,
   input  wire logic  rst_b_in,
   pec_stage_if.stage st
);

   logic [15:0] ff_r [PEC_FF_DEPTH];
   logic [3:0]  skip_cnt_r;
   logic [15:0] sf_word0_r;
   logic [15:0] ambient_r;
   logic        seeded_r;
   logic [7:0]  hold_r;
   logic [9:0]  recal_cnt_r;
   logic        prox_r;

   function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
      absdiff = (a > b) ? a - b : b - a;
   endfunction

   ////////////////////////////////////////////////////////////
   wire logic [17:0] ff_sum  = 18'(ff_r[0]) + 18'(ff_r[1]) + 18'(ff_r[2]) + 18'(ff_r[3]);
   wire logic [15:0] ff_avg  = ff_sum[17:2];
   wire logic        ff_take = st.smp_vld && (skip_cnt_r == st.skip);
   wire logic [15:0] lvl1    = 16'(st.det_rate) << PEC_LSB_SCALE;
   wire logic [15:0] lvl2    = 16'(st.recal_lvl) << PEC_LSB_SCALE;
   wire logic        prox1   = absdiff(ff_r[0], ff_r[PEC_FF_DEPTH-1]) > lvl1;
   wire logic        prox2   = absdiff(ff_avg, ambient_r) > lvl2;
   wire logic        prox_w  = seeded_r && (prox1 || prox2);
   wire logic [7:0]  hold_fp = 8'(st.fp_hold) << PEC_FP_HOLD_SHIFT;
   wire logic [7:0]  hold_lp = 8'(st.lp_hold) << PEC_LP_HOLD_SHIFT;
   wire logic [7:0]  hold_len = st.lowp ? hold_lp : hold_fp;
   wire logic [9:0]  recal_lim = st.lowp ? 10'(st.lp_recal) : st.fp_recal;
   wire logic        recal_fire = seeded_r && st.seq_tick && prox2 && (recal_lim != 10'h000)
                                  && (recal_cnt_r + 10'h001 >= recal_lim);
   wire logic        cal_en  = !prox_r && (hold_r == 8'h00);
   wire logic        slow_en = absdiff(sf_word0_r, st.smp) > st.slow_lvl;

   wire logic signed [16:0] amb_delta = $signed({1'b0, st.smp}) - $signed({1'b0, ambient_r});
   wire logic signed [16:0] amb_step  = amb_delta >>> PEC_AMB_SHIFT;
   wire logic [15:0] amb_nxt = 16'($signed({1'b0, ambient_r}) + amb_step);
   wire logic [15:0] up_pct  = st.up_ofs - (st.up_ofs >> PEC_PCT_SHIFT);
   wire logic [15:0] lo_pct  = st.lo_ofs - (st.lo_ofs >> PEC_PCT_SHIFT);

   ////////////////////////////////////////////////////////////
   // fast fifo with sample skipping
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < PEC_FF_DEPTH; i++) ff_r[i] <= '0;
         skip_cnt_r <= '0;
         seeded_r   <= 1'b0;
      end else if (st.smp_vld && !seeded_r) begin
         for (int i = 0; i < PEC_FF_DEPTH; i++) ff_r[i] <= st.smp;
         seeded_r <= 1'b1;
      end else if (st.smp_vld) begin
         skip_cnt_r <= ff_take ? 4'h0 : skip_cnt_r + 4'h1;
         if (ff_take) begin
            ff_r[0] <= st.smp;
            for (int i = 1; i < PEC_FF_DEPTH; i++) ff_r[i] <= ff_r[i-1];
         end
      end
   end

   // slow filter and ambient tracking
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         sf_word0_r <= '0;
         ambient_r  <= '0;
      end else if (st.smp_vld && !seeded_r) begin
         sf_word0_r <= st.smp;
         ambient_r  <= st.smp;
      end else if (recal_fire) begin
         sf_word0_r <= ff_avg;
         ambient_r  <= ff_avg;
      end else if (st.smp_vld && cal_en && slow_en) begin
         sf_word0_r <= st.smp;
         ambient_r  <= amb_nxt;
      end
   end

   // proximity and calibration hold
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         prox_r <= 1'b0;
         hold_r <= '0;
      end else begin
         prox_r <= prox_w;
         if (prox_w) begin
            hold_r <= hold_len;
         end else if (st.seq_tick && hold_r != 8'h00) begin
            hold_r <= hold_r - 8'h01;
         end
      end
   end

   // recalibration timeout
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in || !prox2 || recal_fire) begin
         recal_cnt_r <= '0;
      end else if (st.seq_tick) begin
         recal_cnt_r <= recal_cnt_r + 10'h001;
      end
   end

   assign st.prox    = prox_r;
   assign st.cal_en  = cal_en;
   assign st.ambient = ambient_r;
   assign st.up_thr  = {1'b0, ambient_r} + {1'b0, up_pct};
   assign st.lo_thr  = (ambient_r > lo_pct) ? ambient_r - lo_pct : 16'h0000;

endmodule

// ### pec_prox_env_cal.sv
// Purpose : proximity detection and ambient compensation for all stages
// Assumes : converter, sequencer and host port run on ref_clk_in
// Notes   : register reads return one cycle after the address
`timescale 1ns/1ns

////////////////////////////////////////////////////////////
// Overview of operation
// - proximity one: fast fifo word0 vs word3 beyond rate times 16
// - proximity two: fast average vs ambient beyond level times 16
// - proximity is either comparator condition
// - hold counts at 0x002 bits 7:4 full power, 11:8 low power
// - recal timeouts at 0x004 bits 9:0 full power, 15:10 low power
// - recal level 0x003 bits 7:0, detection rate bits 13:8
// - ambient calibration stops as soon as proximity is seen
// - skip count at 0x002 bits 3:0 thins fast fifo samples
// - fast fifo period scales with skip count plus one
// - slow filter updates on large change, only without proximity
// - comparator two also catches ambient shift after user contact
// - compensation runs on each conversion beyond the slow level while untouched
// - thresholds follow the tracked ambient level per stage
// - per-stage data and setup held on chip beside controls
// - thresholds from offset percentages; interrupt when crossed
// - upper threshold is ambient plus offset term
// - full power hold: count times 16 sequences after proximity
// - low power hold: count times 4 sequences
// - recalibrate after level exceeded for the whole timeout
// - timeout is field times one sequence of that mode
module pec_prox_env_cal
   import pec_pkg::*;
#(
   parameter int unsigned NUM_STAGES = PEC_NUM_STAGES
)(
   input  wire logic                  ref_clk_in,
   input  wire logic                  rst_b_in,
   input  wire logic                  reg_wr_in,
   input  wire logic [7:0]            reg_addr_in,
   input  wire logic [15:0]           reg_wdata_in,
   output logic      [15:0]           reg_rdata_out,
   input  wire logic                  smp_vld_in,
   input  wire logic [3:0]            smp_stage_in,
   input  wire logic [15:0]           smp_data_in,
   input  wire logic                  seq_done_in,
   input  wire logic                  low_power_in,
   output logic      [NUM_STAGES-1:0] prox_out,
   output logic                       int_out
);

   ////////////////////////////////////////////////////////////
   // shared configuration
   logic [3:0]  skip_r;
   logic [3:0]  fp_hold_r;
   logic [3:0]  lp_hold_r;
   logic [7:0]  recal_lvl_r;
   logic [5:0]  det_rate_r;
   logic [9:0]  fp_recal_r;
   logic [5:0]  lp_recal_r;
   logic [15:0] slow_lvl_r;

   // per-stage setup and state views
   logic [15:0]           up_ofs_r [NUM_STAGES];
   logic [15:0]           lo_ofs_r [NUM_STAGES];
   logic [15:0]           amb_a    [NUM_STAGES];
   logic [16:0]           upthr_a  [NUM_STAGES];
   logic [15:0]           lothr_a  [NUM_STAGES];
   logic [NUM_STAGES-1:0] prox_v;
   logic [NUM_STAGES-1:0] calen_v;
   logic [NUM_STAGES-1:0] active_r;
   logic [NUM_STAGES-1:0] active_nxt;
   logic [NUM_STAGES-1:0] calen_r;
   logic [15:0]           rdata_r;
   logic [15:0]           rdata_nxt;
   logic                  int_r;
   logic [NUM_STAGES-1:0] prox_r;

   ////////////////////////////////////////////////////////////
   // address decode
   wire logic [3:0] addr_idx  = reg_addr_in[3:0];
   wire logic [3:0] addr_bank = reg_addr_in[7:4];
   wire logic       idx_ok    = 32'(addr_idx) < NUM_STAGES;

   wire logic sel_hold  = reg_addr_in == PEC_OFS_HOLD_SKIP;
   wire logic sel_ctrl1 = reg_addr_in == PEC_OFS_CTRL1;
   wire logic sel_recal = reg_addr_in == PEC_OFS_RECAL;
   wire logic sel_slow  = reg_addr_in == PEC_OFS_SLOW_LVL;
   wire logic sel_pstat = reg_addr_in == PEC_OFS_PROX_STAT;
   wire logic sel_cstat = reg_addr_in == PEC_OFS_CAL_STAT;
   wire logic sel_tstat = reg_addr_in == PEC_OFS_THR_STAT;
   wire logic sel_upofs = idx_ok && (addr_bank == PEC_BANK_UP_OFS);
   wire logic sel_loofs = idx_ok && (addr_bank == PEC_BANK_LO_OFS);
   wire logic sel_amb   = idx_ok && (addr_bank == PEC_BANK_AMBIENT);
   wire logic sel_upthr = idx_ok && (addr_bank == PEC_BANK_UP_THR);
   wire logic sel_lothr = idx_ok && (addr_bank == PEC_BANK_LO_THR);

   wire logic wr_hold  = reg_wr_in && sel_hold;
   wire logic wr_ctrl1 = reg_wr_in && sel_ctrl1;
   wire logic wr_recal = reg_wr_in && sel_recal;
   wire logic wr_slow  = reg_wr_in && sel_slow;

   ////////////////////////////////////////////////////////////
   // shared register writes
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         skip_r    <= PEC_RST_HOLD_SKIP[PEC_SKIP_LSB +: 4];
         fp_hold_r <= PEC_RST_HOLD_SKIP[PEC_FP_HOLD_LSB +: 4];
         lp_hold_r <= PEC_RST_HOLD_SKIP[PEC_LP_HOLD_LSB +: 4];
      end else if (wr_hold) begin
         skip_r    <= reg_wdata_in[PEC_SKIP_LSB +: 4];
         fp_hold_r <= reg_wdata_in[PEC_FP_HOLD_LSB +: 4];
         lp_hold_r <= reg_wdata_in[PEC_LP_HOLD_LSB +: 4];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         recal_lvl_r <= PEC_RST_CTRL1[PEC_RLVL_LSB +: 8];
         det_rate_r  <= PEC_RST_CTRL1[PEC_DRATE_LSB +: 6];
      end else if (wr_ctrl1) begin
         recal_lvl_r <= reg_wdata_in[PEC_RLVL_LSB +: 8];
         det_rate_r  <= reg_wdata_in[PEC_DRATE_LSB +: 6];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         fp_recal_r <= PEC_RST_RECAL[PEC_FP_RECAL_LSB +: 10];
         lp_recal_r <= PEC_RST_RECAL[PEC_LP_RECAL_LSB +: 6];
      end else if (wr_recal) begin
         fp_recal_r <= reg_wdata_in[PEC_FP_RECAL_LSB +: 10];
         lp_recal_r <= reg_wdata_in[PEC_LP_RECAL_LSB +: 6];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         slow_lvl_r <= PEC_RST_SLOW_LVL;
      end else if (wr_slow) begin
         slow_lvl_r <= reg_wdata_in;
      end
   end

   ////////////////////////////////////////////////////////////
   // stage engines
   pec_stage_if sif [NUM_STAGES] ();

   for (genvar g = 0; g < NUM_STAGES; g++) begin : g_stage
      wire logic hit   = smp_vld_in && (smp_stage_in == 4'(g));
      wire logic wr_up = reg_wr_in && sel_upofs && (addr_idx == 4'(g));
      wire logic wr_lo = reg_wr_in && sel_loofs && (addr_idx == 4'(g));
      wire logic above = {1'b0, smp_data_in} > upthr_a[g];
      wire logic below = smp_data_in < lothr_a[g];

      // per-stage offsets kept on chip
      always_ff @(posedge ref_clk_in) begin
         if (!rst_b_in) begin
            up_ofs_r[g] <= PEC_RST_STAGE_OFS;
         end else if (wr_up) begin
            up_ofs_r[g] <= reg_wdata_in;
         end
      end

      always_ff @(posedge ref_clk_in) begin
         if (!rst_b_in) begin
            lo_ofs_r[g] <= PEC_RST_STAGE_OFS;
         end else if (wr_lo) begin
            lo_ofs_r[g] <= reg_wdata_in;
         end
      end

      assign sif[g].smp_vld   = hit;
      assign sif[g].smp       = smp_data_in;
      assign sif[g].seq_tick  = seq_done_in;
      assign sif[g].lowp      = low_power_in;
      assign sif[g].skip      = skip_r;
      assign sif[g].fp_hold   = fp_hold_r;
      assign sif[g].lp_hold   = lp_hold_r;
      assign sif[g].fp_recal  = fp_recal_r;
      assign sif[g].lp_recal  = lp_recal_r;
      assign sif[g].recal_lvl = recal_lvl_r;
      assign sif[g].det_rate  = det_rate_r;
      assign sif[g].slow_lvl  = slow_lvl_r;
      assign sif[g].up_ofs    = up_ofs_r[g];
      assign sif[g].lo_ofs    = lo_ofs_r[g];

      assign prox_v[g]  = sif[g].prox;
      assign calen_v[g] = sif[g].cal_en;
      assign amb_a[g]   = sif[g].ambient;
      assign upthr_a[g] = sif[g].up_thr;
      assign lothr_a[g] = sif[g].lo_thr;

      // threshold crossing state, refreshed on each sample
      assign active_nxt[g] = hit ? (above || below) : active_r[g];

      pec_stage u_stage (
         .ref_clk_in (ref_clk_in),
         .rst_b_in   (rst_b_in),
         .st         (sif[g])
      );
   end

   ////////////////////////////////////////////////////////////
   // crossing state, interrupt and status
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         active_r <= '0;
         int_r    <= 1'b0;
         prox_r   <= '0;
         calen_r  <= '0;
      end else begin
         active_r <= active_nxt;
         int_r    <= |active_nxt;
         prox_r   <= prox_v;
         calen_r  <= calen_v;
      end
   end

   ////////////////////////////////////////////////////////////
   // read path
   wire logic [15:0] rd_hold  = {4'h0, lp_hold_r, fp_hold_r, skip_r};
   wire logic [15:0] rd_ctrl1 = {2'b00, det_rate_r, recal_lvl_r};
   wire logic [15:0] rd_recal = {lp_recal_r, fp_recal_r};
   wire logic [15:0] rd_upthr = upthr_a[addr_idx][16] ? 16'hffff : upthr_a[addr_idx][15:0];

   assign rdata_nxt = sel_hold  ? rd_hold :
                      sel_ctrl1 ? rd_ctrl1 :
                      sel_recal ? rd_recal :
                      sel_slow  ? slow_lvl_r :
                      sel_pstat ? 16'(prox_r) :
                      sel_cstat ? 16'(calen_r) :
                      sel_tstat ? 16'(active_r) :
                      sel_upofs ? up_ofs_r[addr_idx] :
                      sel_loofs ? lo_ofs_r[addr_idx] :
                      sel_amb   ? amb_a[addr_idx] :
                      sel_upthr ? rd_upthr :
                      sel_lothr ? lothr_a[addr_idx] :
                      16'h0000;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_out = rdata_r;
   assign prox_out      = prox_r;
   assign int_out       = int_r;

endmodule

// ### pec_prox_env_cal_chk.sv
// Purpose : port-level checks for proximity and ambient calibration
// Assumes : single clock domain, synchronous active-low reset
// Notes   : sees only the top module ports
`timescale 1ns/1ns
module pec_prox_env_cal_chk #(
   parameter int unsigned NUM_STAGES = 12
)(
   input wire logic                  ref_clk_in,
   input wire logic                  rst_b_in,
   input wire logic                  reg_wr_in,
   input wire logic [7:0]            reg_addr_in,
   input wire logic [15:0]           reg_wdata_in,
   input wire logic [15:0]           reg_rdata_out,
   input wire logic                  smp_vld_in,
   input wire logic [3:0]            smp_stage_in,
   input wire logic [15:0]           smp_data_in,
   input wire logic                  seq_done_in,
   input wire logic                  low_power_in,
   input wire logic [NUM_STAGES-1:0] prox_out,
   input wire logic                  int_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_b_in);

   ////////////////////////////////////////
   // write then read of the same offset
   sequence s_wr_rd(logic [7:0] a);
      reg_wr_in && reg_addr_in == a ##1 !reg_wr_in && reg_addr_in == a;
   endsequence
   // no cause for a proximity change
   sequence s_quiet;
      !reg_wr_in && !seq_done_in && (!smp_vld_in || smp_stage_in >= 4'(NUM_STAGES));
   endsequence

   ////////////////////////////////////////
   a_rst_clears: assert property (disable iff (1'b0)
      !rst_b_in |=> reg_rdata_out == 16'h0000 && prox_out == '0 && !int_out)
      else $error("outputs not cleared in reset");
   a_hold_skip_rdbk: assert property (
      s_wr_rd(8'h02) |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 16'h0fff))
      else $error("hold and skip readback wrong");
   a_ctrl_one_rdbk: assert property (
      s_wr_rd(8'h03) |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 16'h3fff))
      else $error("control one readback wrong");
   a_recal_tmo_rdbk: assert property (
      s_wr_rd(8'h04) |=> reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("recal timeout readback wrong");
   a_slow_lvl_rdbk: assert property (
      s_wr_rd(8'h05) |=> reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("slow level readback wrong");
   a_unmapped_reads_zero: assert property (
      reg_addr_in inside {8'h00, 8'h01, [8'h09:8'h0f]} |=> reg_rdata_out == 16'h0000)
      else $error("unmapped read not zero");
   a_prox_needs_cause: assert property (
      s_quiet [*6] |=> $stable(prox_out))
      else $error("proximity changed without sample or tick");
   a_int_needs_sample: assert property (
      (!smp_vld_in || smp_stage_in >= 4'(NUM_STAGES)) [*4] |=> $stable(int_out))
      else $error("interrupt changed without sample");
endmodule

bind pec_prox_env_cal pec_prox_env_cal_chk #(.NUM_STAGES(NUM_STAGES)) u_chk (
   .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .smp_vld_in(smp_vld_in), .smp_stage_in(smp_stage_in), .smp_data_in(smp_data_in),
   .seq_done_in(seq_done_in), .low_power_in(low_power_in), .prox_out(prox_out),
   .int_out(int_out));

// ### pec_conv_model.sv
// Purpose : converter and sequencer model feeding stage samples
// Assumes : one-cycle valid and sequence-end pulses
// Notes   : data bus shows inverted code once released
`timescale 1ns/1ns
module pec_conv_model (
   input  wire logic        ref_clk_in,
   output logic             smp_vld_out,
   output logic [3:0]       smp_stage_out,
   output logic [15:0]      smp_data_out,
   output logic             seq_done_out
);
   initial begin
      smp_vld_out = 1'b0;
      smp_stage_out = 4'h0;
      smp_data_out = 16'h0000;
      seq_done_out = 1'b0;
   end

   ////////////////////////////////////////
   task automatic send(input logic [3:0] stg, input logic [15:0] val);
      @(posedge ref_clk_in);
      smp_vld_out   <= 1'b1;
      smp_stage_out <= stg;
      smp_data_out  <= val;
      @(posedge ref_clk_in);
      smp_vld_out  <= 1'b0;
      smp_data_out <= ~val;
   endtask

   task automatic tick();
      @(posedge ref_clk_in);
      seq_done_out <= 1'b1;
      @(posedge ref_clk_in);
      seq_done_out <= 1'b0;
   endtask
endmodule

// ### tb.sv
// Purpose : self-checking bench for proximity and ambient calibration
// Assumes : 25 MHz clock, register reads one cycle late
// Notes   : slow filter kept off except in t_slow, so elsewhere ambient moves only on the seeding sample and on recal
`timescale 1ns/1ns
module tb;
   import pec_pkg::*;
   logic        ref_clk_in   = 1'b0;
   logic        rst_b_in     = 1'b0;
   logic        reg_wr_in    = 1'b0;
   logic [7:0]  reg_addr_in  = 8'h00;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic        low_power_in = 1'b0;
   logic [15:0] reg_rdata_out;
   logic        smp_vld;
   logic [3:0]  smp_stage;
   logic [15:0] smp_data;
   logic        seq_done;
   logic [11:0] prox_out;
   logic        int_out;
   int          failures = 0;
   int          n_tests  = 0;
   int          cycles   = 0;

   always #20 ref_clk_in = ~ref_clk_in;

   pec_prox_env_cal #(.NUM_STAGES(12)) dut (
      .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .smp_vld_in(smp_vld), .smp_stage_in(smp_stage),
      .smp_data_in(smp_data), .seq_done_in(seq_done), .low_power_in(low_power_in),
      .prox_out(prox_out), .int_out(int_out));

   pec_conv_model conv (
      .ref_clk_in(ref_clk_in), .smp_vld_out(smp_vld), .smp_stage_out(smp_stage),
      .smp_data_out(smp_data), .seq_done_out(seq_done));

   ////////////////////////////////////////
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      repeat (2) @(posedge ref_clk_in);
      #1 d = reg_rdata_out;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      check(d, e);
   endtask

   task automatic bchk(input logic [7:0] a, input int b, input logic e);
      logic [15:0] d;
      rd(a, d);
      check({15'h0, d[b]}, {15'h0, e});
   endtask

   task automatic pchk(input int s, input logic e);
      check({15'h0, prox_out[s]}, {15'h0, e});
   endtask

   task automatic smp(input logic [3:0] s, input logic [15:0] v, input int n);
      repeat (n) conv.send(s, v);
      repeat (4) @(posedge ref_clk_in);
   endtask

   task automatic ticks(input int n);
      repeat (n) conv.tick();
      repeat (4) @(posedge ref_clk_in);
   endtask

   // stage 3 calibration stays off for n ticks after proximity ends
   task automatic hold_run(input int n);
      ticks(n - 1);
      bchk(PEC_OFS_CAL_STAT, 3, 1'b0);
      ticks(1);
      bchk(PEC_OFS_CAL_STAT, 3, 1'b1);
   endtask

   ////////////////////////////////////////
   task automatic t_regs();
      logic [7:0]  a [4] = '{PEC_OFS_HOLD_SKIP, PEC_OFS_CTRL1, PEC_OFS_RECAL, PEC_OFS_SLOW_LVL};
      logic [15:0] m [4] = '{16'h0fff, 16'h3fff, 16'hffff, 16'hffff};
      for (int i = 0; i < 4; i++) begin
         rchk(a[i], 16'h0000);
         wr(a[i], 16'hffff);
         rchk(a[i], m[i]);
         wr(a[i], 16'h0000);
      end
      rchk(8'h09, 16'h0000);
      smp(4'hd, 16'hffff, 1);
      check({4'h0, prox_out}, 16'h0000);
      wr(PEC_OFS_SLOW_LVL, 16'hffff);
   endtask

   task automatic t_thresh();
      logic [15:0] v [4] = '{16'd1193, 16'd1192, 16'd807, 16'd808};
      logic        e [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      wr(PEC_OFS_CTRL1, 16'h3fff);
      wr({PEC_BANK_UP_OFS, 4'h6}, 16'h0100);
      wr({PEC_BANK_LO_OFS, 4'h6}, 16'h0100);
      smp(4'h6, 16'd1000, 2);
      check({15'h0, int_out}, 16'h0000);
      rchk({PEC_BANK_AMBIENT, 4'h6}, 16'd1000);
      rchk({PEC_BANK_UP_THR, 4'h6}, 16'd1192);
      rchk({PEC_BANK_LO_THR, 4'h6}, 16'd808);
      for (int i = 0; i < 4; i++) begin
         smp(4'h6, v[i], 1);
         check({15'h0, int_out}, {15'h0, e[i]});
      end
      // flush the fast fifo so comparator one stays quiet later
      smp(4'h6, 16'd1000, 4);
      check({15'h0, int_out}, 16'h0000);
   endtask

   task automatic t_comp1();
      wr(PEC_OFS_CTRL1, 16'h04ff);
      smp(4'h2, 16'd1000, 1);
      smp(4'h2, 16'd1064, 1);
      pchk(2, 1'b0);
      smp(4'h2, 16'd1065, 1);
      check({4'h0, prox_out}, 16'h0004);
      bchk(PEC_OFS_PROX_STAT, 2, 1'b1);
      bchk(PEC_OFS_CAL_STAT, 2, 1'b0);
      smp(4'h2, 16'd1000, 1);
      pchk(2, 1'b0);
   endtask

   task automatic t_comp2_hold();
      wr(PEC_OFS_CTRL1, 16'h3f01);
      wr(PEC_OFS_HOLD_SKIP, 16'h0210);
      smp(4'h3, 16'd2000, 1);
      smp(4'h3, 16'd2017, 3);
      pchk(3, 1'b0);
      for (int k = 0; k < 2; k++) begin
         smp(4'h3, 16'd2017, k == 0 ? 1 : 4);
         pchk(3, 1'b1);
         smp(4'h3, 16'd2000, 4);
         pchk(3, 1'b0);
         hold_run(k == 0 ? 16 : 8);
         @(posedge ref_clk_in);
         low_power_in <= (k == 0);
      end
   endtask

   task automatic t_recal();
      wr(PEC_OFS_RECAL, 16'h0003);
      smp(4'h4, 16'd3000, 1);
      smp(4'h4, 16'd3100, 4);
      pchk(4, 1'b1);
      ticks(2);
      rchk({PEC_BANK_AMBIENT, 4'h4}, 16'd3000);
      ticks(1);
      rchk({PEC_BANK_AMBIENT, 4'h4}, 16'd3100);
      rchk({PEC_BANK_UP_THR, 4'h4}, 16'd3100);
      smp(4'h4, 16'd3100, 1);
      pchk(4, 1'b0);
      wr(PEC_OFS_RECAL, 16'h0000);
   endtask

   task automatic t_skip();
      wr(PEC_OFS_HOLD_SKIP, 16'h0001);
      smp(4'h5, 16'd500, 1);
      smp(4'h5, 16'd517, 4);
      pchk(5, 1'b0);
      smp(4'h5, 16'd517, 4);
      pchk(5, 1'b1);
   endtask

   // ambient tracks by a sixteenth of the step, frozen once proximity is up
   task automatic t_slow();
      wr(PEC_OFS_SLOW_LVL, 16'h0004);
      smp(4'h7, 16'd1600, 1);
      smp(4'h7, 16'd1616, 1);
      rchk({PEC_BANK_AMBIENT, 4'h7}, 16'd1601);
      smp(4'h7, 16'd1900, 2);
      pchk(7, 1'b1);
      rchk({PEC_BANK_AMBIENT, 4'h7}, 16'd1619);
   endtask

   initial begin
      repeat (12) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      t_regs();
      t_thresh();
      t_comp1();
      t_comp2_hold();
      t_recal();
      t_skip();
      t_slow();
      end_sim();
   end
endmodule
